// >>> sto_input_logic.sv
// Summary of operation
// [R01] enable and active status only when both safe channels are high
// [R02] torque-off indication high only when both channels are low
// [R03] either channel low enters torque-off even if the other stays high
// [R04] sensor drives both channels together; single-channel activity means faulty wiring
// [R05] low test pulses up to 1 ms are ignored while enabled
// [R06] switch-off completes within at least 2.5 ms after a valid request
// [R07] drive status word bit 10 set while controller is disconnected
// [R08] internal fault forces torqueless fail-safe state whatever the inputs
// [R09] pwm toward power drivers blocked in torque-off
// [R10] enable led steady when enabled, blinking while safety function active
// [R11] only the enable led shows status; other safety leds stay dark
// [R12] withdrawal of request re-enables automatically; restart confirmation is external
// [R13] no short-circuit detection, only logic levels evaluated
// [R14] inputs synchronised before filtering; led blinks at a fixed rate
`timescale 1ns/1ps
`include "sto_params.svh"

module sto_input_logic
  import sto_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic SAFE_IN_A,
  input wire logic SAFE_IN_B,
  input wire logic [5:0] PWM_IN,
  input wire logic INTERNAL_FAULT,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic CONTROLLER_ENABLE,
  output logic TORQUE_OFF_INDICATION,
  output logic [5:0] PWM_OUT,
  output logic [15:0] DRIVE_STATUS_WORD,
  output logic ENABLE_LED,
  output logic OTHER_LEDS,
  output logic CHANNEL_MISMATCH,
  output logic IRQ
);

  sto_chan_t sync1_r;
  sto_chan_t sync2_r;
  sto_chan_t filt_r;
  logic [`STO_CNT_W-1:0] low_cnt_r;
  logic [`STO_CNT_W-1:0] off_cnt_r;
  logic [`STO_CNT_W-1:0] blink_cnt_r;
  logic blink_r;
  sto_state_t state_r;
  sto_state_t state_nxt;
  logic fault_r;
  logic pwm_en_r;
  logic [`STO_IRQ_W-1:0] irq_stat_r;
  logic [`STO_IRQ_W-1:0] irq_mask_r;
  logic [`STO_IRQ_W-1:0] irq_evt;
  logic both_high;
  logic both_low;
  logic fail_safe;
  logic prev_active_r;
  logic prev_mismatch_r;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rdata_nxt;

  // two-stage synchroniser; first stage feeds nothing but the second
  always_ff @(posedge CLK) begin // [R14]
    if (RESET) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= '{a: SAFE_IN_A, b: SAFE_IN_B};
      sync2_r <= sync1_r;
    end
  end

  // pulse filter: a low must persist past 1 ms before it counts as a request;
  // rising edges pass at once so release is not delayed
  always_ff @(posedge CLK) begin // [R05]
    if (RESET) begin
      low_cnt_r <= '0;
      filt_r <= '0;
    end else if (sync2_r.a && sync2_r.b) begin
      low_cnt_r <= '0;
      filt_r <= '{a: 1'b1, b: 1'b1};
    end else if (low_cnt_r >= `STO_CNT_W'(`STO_PULSE_CYC)) begin
      filt_r <= sync2_r; // [R13]
    end else begin
      low_cnt_r <= low_cnt_r + `STO_CNT_W'(1);
    end
  end

  assign both_high = filt_r.a & filt_r.b; // [R01]
  assign both_low = ~filt_r.a & ~filt_r.b; // [R02]
  assign fail_safe = fault_r | INTERNAL_FAULT; // [R08]

  // state: any low channel or a fault leaves active, switch-off window follows
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_ACTIVE: begin
        if (!both_high || fail_safe) begin // [R03]
          state_nxt = ST_STOPPING;
        end
      end
      ST_STOPPING: begin
        if (off_cnt_r >= `STO_CNT_W'(`STO_OFF_CYC - 1)) begin // [R06]
          state_nxt = ST_OFF;
        end
      end
      ST_OFF: begin
        // automatic restart; restart confirmation lies outside
        if (both_high && !fail_safe) begin // [R12]
          state_nxt = ST_ACTIVE;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // switch-off timer; pwm already blocked, this holds the window closed
  always_ff @(posedge CLK) begin // [R06]
    if (RESET || state_r != ST_STOPPING) begin
      off_cnt_r <= '0;
    end else begin
      off_cnt_r <= off_cnt_r + `STO_CNT_W'(1);
    end
  end

  // pwm gate: blocked the cycle the request arrives, not after the window
  always_ff @(posedge CLK) begin // [R09]
    if (RESET) begin
      PWM_OUT <= '0;
    end else if (state_nxt == ST_ACTIVE && pwm_en_r) begin
      PWM_OUT <= PWM_IN;
    end else begin
      PWM_OUT <= '0;
    end
  end

  // enable, indication and status word outputs
  always_ff @(posedge CLK) begin
    if (RESET) begin
      CONTROLLER_ENABLE <= 1'b0;
      TORQUE_OFF_INDICATION <= 1'b0;
      DRIVE_STATUS_WORD <= '0;
      // reset leaves the drive off, so the status bit reports it at once
      DRIVE_STATUS_WORD[`STO_STATUS_BIT] <= 1'b1; // [R07]
      CHANNEL_MISMATCH <= 1'b0;
    end else begin
      CONTROLLER_ENABLE <= (state_nxt == ST_ACTIVE); // [R01]
      TORQUE_OFF_INDICATION <= both_low; // [R02]
      DRIVE_STATUS_WORD <= '0;
      DRIVE_STATUS_WORD[`STO_STATUS_BIT] <= (state_nxt != ST_ACTIVE); // [R07]
      // single-channel low that outlasts the pulse filter is reported, never trusted as healthy
      CHANNEL_MISMATCH <= filt_r.a ^ filt_r.b; // [R04]
    end
  end

  // blink timer for the enable led; free running keeps the rate fixed
  always_ff @(posedge CLK) begin // [R14]
    if (RESET) begin
      blink_cnt_r <= '0;
      blink_r <= 1'b0;
    end else if (blink_cnt_r >= `STO_CNT_W'(`STO_BLINK_CYC - 1)) begin
      blink_cnt_r <= '0;
      blink_r <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + `STO_CNT_W'(1);
    end
  end

  // led: steady when enabled, blinking otherwise; non-safe display
  always_ff @(posedge CLK) begin // [R10]
    if (RESET) begin
      ENABLE_LED <= 1'b0;
      OTHER_LEDS <= 1'b0;
    end else begin
      ENABLE_LED <= (state_nxt == ST_ACTIVE) ? 1'b1 : blink_r;
      OTHER_LEDS <= 1'b0; // [R11]
    end
  end

  // apb decode; zero wait states, ready in the first access cycle only
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_en = PSEL & PENABLE & ~PWRITE;
  assign addr_ok = (PADDR == `STO_OFS_CTRL) || (PADDR == `STO_OFS_STAT) ||
                   (PADDR == `STO_OFS_IRQ_STAT) || (PADDR == `STO_OFS_IRQ_MASK) ||
                   (PADDR == `STO_OFS_DSW);

  // control register: software fault injection forces fail-safe
  always_ff @(posedge CLK) begin
    if (RESET) begin
      fault_r <= 1'b0;
      pwm_en_r <= 1'b1;
    end else if (wr_en && PADDR == `STO_OFS_CTRL) begin
      fault_r <= PWDATA[`STO_CTRL_FAULT]; // [R08]
      pwm_en_r <= PWDATA[`STO_CTRL_PWM_EN];
    end
  end

  // event edges for the interrupt status
  always_ff @(posedge CLK) begin
    if (RESET) begin
      prev_active_r <= 1'b0;
      prev_mismatch_r <= 1'b0;
    end else begin
      prev_active_r <= (state_r == ST_ACTIVE);
      prev_mismatch_r <= filt_r.a ^ filt_r.b;
    end
  end

  always_comb begin
    irq_evt = '0;
    irq_evt[`STO_IRQ_OFF] = prev_active_r & (state_r != ST_ACTIVE);
    irq_evt[`STO_IRQ_ON] = ~prev_active_r & (state_r == ST_ACTIVE);
    irq_evt[`STO_IRQ_DISC] = ~prev_mismatch_r & (filt_r.a ^ filt_r.b);
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_stat_r <= '0;
    end else if (wr_en && PADDR == `STO_OFS_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~PWDATA[`STO_IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_mask_r <= '0;
    end else if (wr_en && PADDR == `STO_OFS_IRQ_MASK) begin
      irq_mask_r <= PWDATA[`STO_IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end

  // read mux
  always_comb begin
    rdata_nxt = '0;
    case (PADDR)
      `STO_OFS_CTRL: begin
        rdata_nxt[`STO_CTRL_FAULT] = fault_r;
        rdata_nxt[`STO_CTRL_PWM_EN] = pwm_en_r;
      end
      `STO_OFS_STAT: begin
        rdata_nxt[5:0] = {INTERNAL_FAULT, CHANNEL_MISMATCH, TORQUE_OFF_INDICATION,
                          CONTROLLER_ENABLE, filt_r.b, filt_r.a};
      end
      `STO_OFS_IRQ_STAT: rdata_nxt[`STO_IRQ_W-1:0] = irq_stat_r;
      `STO_OFS_IRQ_MASK: rdata_nxt[`STO_IRQ_W-1:0] = irq_mask_r;
      `STO_OFS_DSW: rdata_nxt[`STO_STATUS_W-1:0] = DRIVE_STATUS_WORD;
      default: rdata_nxt = '0;
    endcase
  end

  // registered answer: setup then access, ready in the access cycle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PRDATA <= '0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~addr_ok;
      PRDATA <= (PSEL & ~PENABLE & ~PWRITE) ? rdata_nxt : '0;
    end
  end

endmodule // sto_input_logic

// >>> sto_params.svh
`ifndef STO_PARAMS_SVH
`define STO_PARAMS_SVH

// clock rate in kHz (250 MHz)
`define STO_CLK_KHZ 250000
// longest tolerated low test pulse, microseconds
`define STO_PULSE_US 1000
// glitch filter length in cycles, derived from the pulse time
`define STO_PULSE_CYC ((`STO_PULSE_US * `STO_CLK_KHZ) / 1000)
// switch-off window, microseconds (least 2500, typical 4000)
`define STO_OFF_US 2500
`define STO_OFF_CYC ((`STO_OFF_US * `STO_CLK_KHZ) / 1000)
// blink half period, microseconds
`define STO_BLINK_US 250000
// divide first: the product would overflow 32-bit arithmetic
`define STO_BLINK_CYC ((`STO_BLINK_US / 1000) * `STO_CLK_KHZ)
// counter width, wide enough for the blink count
`define STO_CNT_W 26
// drive status word field
`define STO_STATUS_W 16
`define STO_STATUS_BIT 10

// apb register map
`define STO_ADDR_W 12
`define STO_OFS_CTRL 12'h000
`define STO_OFS_STAT 12'h004
`define STO_OFS_IRQ_STAT 12'h008
`define STO_OFS_IRQ_MASK 12'h00C
`define STO_OFS_DSW 12'h010
// control bits
`define STO_CTRL_FAULT 0
`define STO_CTRL_PWM_EN 1
// irq bits
`define STO_IRQ_W 3
`define STO_IRQ_OFF 0
`define STO_IRQ_ON 1
`define STO_IRQ_DISC 2

`endif

// >>> sto_pkg.sv
package sto_pkg;

  // channel pair after synchronising or filtering
  typedef struct packed {
    logic a;
    logic b;
  } sto_chan_t;

  // apb request bundle
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } sto_apb_req_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_STOPPING,
    ST_ACTIVE
  } sto_state_t;

endpackage

// >>> sto_input_logic_asserts.sv
`timescale 1ns/1ps
module sto_asserts (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic SAFE_IN_A,
  input wire logic SAFE_IN_B,
  input wire logic INTERNAL_FAULT,
  input wire logic CONTROLLER_ENABLE,
  input wire logic TORQUE_OFF_INDICATION,
  input wire logic [5:0] PWM_OUT,
  input wire logic [15:0] DRIVE_STATUS_WORD,
  input wire logic ENABLE_LED,
  input wire logic OTHER_LEDS,
  input wire logic CHANNEL_MISMATCH
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_fault;
    INTERNAL_FAULT;
  endsequence
  property p_en_both;
    CONTROLLER_ENABLE |-> !TORQUE_OFF_INDICATION && !CHANNEL_MISMATCH;
  endproperty
  property p_toi;
    TORQUE_OFF_INDICATION |-> !CONTROLLER_ENABLE;
  endproperty
  // the sync stages make enable trail the inputs by several edges
  property p_rise;
    $rose(CONTROLLER_ENABLE) |-> $past(SAFE_IN_A, 3) && $past(SAFE_IN_B, 3);
  endproperty
  property p_fault;
    s_fault |=> !CONTROLLER_ENABLE && PWM_OUT == 6'h00;
  endproperty
  property p_pwm;
    !CONTROLLER_ENABLE |-> PWM_OUT == 6'h00;
  endproperty
  property p_dsw;
    DRIVE_STATUS_WORD == {5'h00, !CONTROLLER_ENABLE, 10'h000};
  endproperty
  property p_led;
    CONTROLLER_ENABLE [*2] |-> ENABLE_LED;
  endproperty
  property p_other;
    OTHER_LEDS == 1'h0;
  endproperty
  a_en_both: assert property (p_en_both) else $error("enable without both channels");
  a_toi: assert property (p_toi) else $error("indication while enabled");
  a_rise: assert property (p_rise) else $error("enable rose without both inputs");
  a_fault: assert property (p_fault) else $error("fault did not drop enable");
  a_pwm: assert property (p_pwm) else $error("pwm passed while off");
  a_dsw: assert property (p_dsw) else $error("status word wrong");
  a_led: assert property (p_led) else $error("led not steady");
  a_other: assert property (p_other) else $error("other leds lit");
endmodule // sto_asserts
bind sto_input_logic sto_asserts i_sto_asserts (.*);

// >>> sto_sensor_model.sv
`timescale 1ns/1ps
// external two-channel sensor; restart confirmation is its business
module sto_sensor_model (
  input wire logic clk,
  output logic ch_a = 1'b0,
  output logic ch_b = 1'b0
);
  // in set_both the channels switch on one edge, never alone
  task automatic set_both(input logic v);
    @(posedge clk);
    ch_a <= v;
    ch_b <= v;
  endtask
  // test pulse, caller keeps it under the tolerated length
  task automatic pulse_a(input int n);
    @(posedge clk);
    ch_a <= 1'b0;
    repeat (n) @(posedge clk);
    ch_a <= 1'b1;
  endtask
endmodule // sto_sensor_model

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic flt = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] pwm_in = 6'h00;
  logic sa, sb, pready, pslverr, en, toi, led, oled, mis, irq, e;
  logic [31:0] prdata, q;
  logic [5:0] pwm;
  logic [15:0] dsw;
  int n_errors = 0;
  int n_compared = 0;
  // 250 MHz
  always #2 clk = ~clk;
  sto_input_logic i_sto_input_logic (.CLK(clk), .RESET(rst), .SAFE_IN_A(sa), .SAFE_IN_B(sb),
    .PWM_IN(pwm_in), .INTERNAL_FAULT(flt), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CONTROLLER_ENABLE(en), .TORQUE_OFF_INDICATION(toi), .PWM_OUT(pwm),
    .DRIVE_STATUS_WORD(dsw), .ENABLE_LED(led), .OTHER_LEDS(oled),
    .CHANNEL_MISMATCH(mis), .IRQ(irq));
  sto_sensor_model i_sto_sensor_model (.clk(clk), .ch_a(sa), .ch_b(sb));
  task chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task end_sim;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one apb transfer; ready and data taken at the rising edge that completes it
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 64);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 64) begin
      n_errors++;
      end_sim();
    end
  endtask
  task t_reset;
    repeat (4) @(negedge clk);
    chk(en, 1'b0);
    chk(toi, 1'b1);
    chk(pwm, 6'h00);
    chk(dsw, 32'h400);
    chk(oled, 1'b0);
    $display("reset test done");
  endtask
  task t_enable;
    int i;
    @(posedge clk);
    pwm_in <= 6'h2A;
    i_sto_sensor_model.set_both(1'b1);
    for (i = 0; i < 40 && en !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    chk(en, 1'b1);
    chk(pwm, 6'h2A);
    chk(dsw, 32'h0);
    chk(toi, 1'b0);
    chk(led, 1'b1);
    $display("enable test done");
  endtask
  // short test pulse must leave the drive running
  task t_pulse;
    int d;
    d = 0;
    fork
      i_sto_sensor_model.pulse_a(1000);
      repeat (1010) begin
        @(negedge clk);
        if (en !== 1'b1 || mis !== 1'b0) d++;
      end
    join
    chk(d, 0);
    $display("pulse test done");
  endtask
  task t_apb;
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h07);
    apb(1'b0, 12'h020, 32'h0);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, 12'h00C, 32'h7);
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h2);
    chk(irq, 1'b1);
    apb(1'b1, 12'h008, 32'h2);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    $display("apb test done");
  endtask
  task t_fault;
    @(posedge clk);
    flt <= 1'b1;
    repeat (2) @(negedge clk);
    chk(en, 1'b0);
    chk(pwm, 6'h00);
    chk(dsw, 32'h400);
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h1);
    apb(1'b1, 12'h008, 32'h1);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    @(posedge clk);
    flt <= 1'b0;
    repeat (100) @(negedge clk);
    chk(en, 1'b0);
    $display("fault test done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_enable();
    t_pulse();
    t_apb();
    t_fault();
    end_sim();
  end
endmodule // tb
